// ==== rtl/osw_pkg.sv ====
// Constants, register map and carrier types of the octal switch host
// Notes on behaviour
// (R1) Device latches shifted command on select rise
// (R2) Device loads fault word on select fall
// (R3) Device ignores clock, floats output while deselected
// (R4) Serial clock low whenever select changes
// (R5) Serial clock low while device not selected
// (R6) Device samples command bit on clock fall
// (R7) Device updates data output on clock rise
// (R8) Eight bits, eight clocks per transfer
// (R9) Command sent from output eight down to one
// (R10) First rising edge shows output eight status
// (R11) Shift path is first in, first out
// (R12) One turns output on, zero off
// (R13) Status one means faulted, zero normal
// (R14) Enable low stops drive and fault reporting
// (R15) Outputs five, six OR direct pins in
// (R16) PWM outputs commanded off, rate below 2 kHz
// (R17) Logic undervoltage holds device in reset
// (R18) Writes spaced more than 300 us apart
// (R19) Classify fault by previously sent command bit
// (R20) Open-load result accepted after fault delay; host classifies open load at every frame end with no delay
// (R21) Open-load fault latched until read
// (R22) Undervoltage clears outputs and fault status
// (R23) Reset clears latch, status, floats data output
// (R24) Extra clocks: latch keeps last eight bits
package osw_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_KHZ       = 25000;
  localparam int T_LEAD_NS     = 100;
  localparam int T_LAG_NS      = 50;
  localparam int T_GAP_US      = 300;
  localparam int PWM_MAX_HZ    = 2000;
  localparam int PWM_STEPS     = 256;
  localparam int LEAD_CYC      = (T_LEAD_NS * CLK_KHZ + 999999) / 1000000;
  localparam int LAG_CYC       = (T_LAG_NS * CLK_KHZ + 999999) / 1000000;
  // Strictly more than the spacing time
  localparam int GAP_CYC       = T_GAP_US * CLK_KHZ / 1000 + 1;
  localparam int PWM_STEP_CYC  = (CLK_KHZ * 1000 + PWM_MAX_HZ * PWM_STEPS - 1)
                                 / (PWM_MAX_HZ * PWM_STEPS);
  localparam int SCLK_HALF_CYC = 4;
  localparam int WORD_BITS     = 8;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_GO    = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_FAULT = 8'h10;
  localparam logic [7:0] OFS_OPEN  = 8'h14;
  localparam logic [7:0] OFS_SHORT = 8'h18;
  localparam logic [7:0] OFS_DUTY  = 8'h1c;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_PWM5_BIT = 1;
  localparam int CTRL_PWM6_BIT = 2;
  localparam int CMD_OUT5_BIT  = 4;
  localparam int CMD_OUT6_BIT  = 5;

  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [7:0]  CMD_RST  = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } osw_bus_type;

  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic serial_cmd_in;
    logic direct_drive_five;
    logic direct_drive_six;
    logic enable;
  } osw_pins_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HI,
    ST_LO,
    ST_LAG
  } osw_state_type;

endpackage

// ==== rtl/osw_pwm.sv ====
// Rate-limited PWM generator for one direct-drive pin
`timescale 1ns/10ps
module osw_pwm #(
  parameter int STEP_CYC = osw_pkg::PWM_STEP_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [7:0] duty,
  output logic            pwm_out
);

  logic [15:0] pre_r;
  logic [15:0] pre_nxt;
  logic [7:0]  step_r;
  logic [7:0]  step_nxt;
  logic        out_r;
  logic        out_nxt;

  if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_chk
    $error("osw_pwm: STEP_CYC out of range");
  end

  // ==========================================================
  // Period is 256 steps of STEP_CYC cycles; any STEP_CYC at or above the default keeps it under the maximum rate
  always_comb begin
    pre_nxt  = pre_r;
    step_nxt = step_r;
    out_nxt  = 1'b0;
    if (run) begin
      if (pre_r == 16'(STEP_CYC - 1)) begin
        pre_nxt  = 16'h0000;
        step_nxt = step_r + 8'h01;
      end else begin
        pre_nxt = pre_r + 16'h0001;
      end
      out_nxt = (step_r < duty);  // see (R16)
    end else begin
      pre_nxt  = 16'h0000;
      step_nxt = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_r  <= 16'h0000;
      step_r <= 8'h00;
      out_r  <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      step_r <= step_nxt;
      out_r  <= out_nxt;
    end
  end

  assign pwm_out = out_r;

endmodule

// ==== rtl/osw_host.sv ====
// Host controller driving the octal serial switch over its serial pins
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module osw_host #(
  parameter int GAP_CYC   = osw_pkg::GAP_CYC,
  parameter int HALF_CYC  = osw_pkg::SCLK_HALF_CYC,
  parameter int STEP_CYC  = osw_pkg::PWM_STEP_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire osw_pkg::osw_bus_type bus,
  output logic [31:0]               rdata,
  output osw_pkg::osw_pins_type     pins,
  input  wire logic                 switch_status_in
);

  if (HALF_CYC < 4 || HALF_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 65535)
  begin : g_chk
    $error("osw_host: timing parameter out of range");
  end

  // ==========================================================
  // Register group
  logic [2:0]  ctrl_r;
  logic [2:0]  ctrl_nxt;
  logic [7:0]  cmd_r;
  logic [7:0]  cmd_nxt;
  logic [15:0] duty_r;
  logic [15:0] duty_nxt;
  logic        go_r;
  logic        go_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Link group
  osw_pkg::osw_state_type st_r;
  osw_pkg::osw_state_type st_nxt;
  logic [7:0]  tmr_r;
  logic [7:0]  tmr_nxt;
  logic [2:0]  bit_r;
  logic [2:0]  bit_nxt;
  logic [7:0]  tx_r;
  logic [7:0]  tx_nxt;
  logic [7:0]  rx_r;
  logic [7:0]  rx_nxt;
  logic [7:0]  sent_r;
  logic [7:0]  sent_nxt;
  logic [7:0]  prev_r;
  logic [7:0]  prev_nxt;
  logic        have_prev_r;
  logic        have_prev_nxt;
  logic        cls_valid_r;
  logic        cls_valid_nxt;
  logic [7:0]  fault_r;
  logic [7:0]  fault_nxt;
  logic [7:0]  open_r;
  logic [7:0]  open_nxt;
  logic [7:0]  short_r;
  logic [7:0]  short_nxt;
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  logic        sel_n_r;
  logic        sel_n_nxt;
  logic        sclk_r;
  logic        sclk_nxt;
  logic        mosi_r;
  logic        mosi_nxt;
  logic        sync1_r;
  logic        sync2_r;
  logic        take;
  logic [7:0]  word;
  logic [1:0]  pwm_out;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Command bits of PWM-driven outputs are always sent as off
  always_comb begin
    word = cmd_r;
    if (ctrl_r[osw_pkg::CTRL_PWM5_BIT]) begin
      word[osw_pkg::CMD_OUT5_BIT] = 1'b0;  // see (R16)
    end
    if (ctrl_r[osw_pkg::CTRL_PWM6_BIT]) begin
      word[osw_pkg::CMD_OUT6_BIT] = 1'b0;  // see (R16)
    end
  end

  assign take = (st_r == osw_pkg::ST_IDLE) && go_r && (gap_r == 16'h0000);

  // ==========================================================
  // Register bus
  always_comb begin
    ctrl_nxt  = ctrl_r;
    cmd_nxt   = cmd_r;
    duty_nxt  = duty_r;
    go_nxt    = go_r & ~take;
    rdata_nxt = 32'h0000_0000;
    if (bus.wr) begin
      if (hit(bus.addr, osw_pkg::OFS_CTRL)) begin
        ctrl_nxt = bus.wdata[2:0];
      end else if (hit(bus.addr, osw_pkg::OFS_CMD)) begin
        cmd_nxt = bus.wdata[7:0];  // see (R12)
      end else if (hit(bus.addr, osw_pkg::OFS_GO)) begin
        go_nxt = 1'b1;
      end else if (hit(bus.addr, osw_pkg::OFS_DUTY)) begin
        duty_nxt = bus.wdata[15:0];
      end
    end
    if (bus.rd) begin
      if (hit(bus.addr, osw_pkg::OFS_CTRL)) begin
        rdata_nxt = {29'h0, ctrl_r};
      end else if (hit(bus.addr, osw_pkg::OFS_CMD)) begin
        rdata_nxt = {24'h0, cmd_r};
      end else if (hit(bus.addr, osw_pkg::OFS_STAT)) begin
        rdata_nxt = {28'h0, cls_valid_r, gap_r != 16'h0000, go_r,
                     st_r != osw_pkg::ST_IDLE};
      end else if (hit(bus.addr, osw_pkg::OFS_FAULT)) begin
        rdata_nxt = {24'h0, fault_r};
      end else if (hit(bus.addr, osw_pkg::OFS_OPEN)) begin
        rdata_nxt = {24'h0, open_r};
      end else if (hit(bus.addr, osw_pkg::OFS_SHORT)) begin
        rdata_nxt = {24'h0, short_r};
      end else if (hit(bus.addr, osw_pkg::OFS_DUTY)) begin
        rdata_nxt = {16'h0, duty_r};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r  <= osw_pkg::CTRL_RST;
      cmd_r   <= osw_pkg::CMD_RST;
      duty_r  <= osw_pkg::DUTY_RST;
      go_r    <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cmd_r   <= cmd_nxt;
      duty_r  <= duty_nxt;
      go_r    <= go_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Serial link sequencer
  always_comb begin
    st_nxt        = st_r;
    tmr_nxt       = tmr_r;
    bit_nxt       = bit_r;
    tx_nxt        = tx_r;
    rx_nxt        = rx_r;
    sent_nxt      = sent_r;
    prev_nxt      = prev_r;
    have_prev_nxt = have_prev_r;
    cls_valid_nxt = cls_valid_r;
    fault_nxt     = fault_r;
    open_nxt      = open_r;
    short_nxt     = short_r;
    gap_nxt       = (gap_r != 16'h0000) ? gap_r - 16'h0001 : gap_r;
    sel_n_nxt     = sel_n_r;
    sclk_nxt      = sclk_r;
    mosi_nxt      = mosi_r;
    case (st_r)
      osw_pkg::ST_IDLE: begin
        sclk_nxt = 1'b0;  // see (R5)
        if (take) begin  // see (R18)
          st_nxt    = osw_pkg::ST_LEAD;
          sel_n_nxt = 1'b0;  // see (R4)
          tx_nxt    = word;
          sent_nxt  = word;
          mosi_nxt  = word[7];  // see (R9)
          bit_nxt   = 3'h0;
          tmr_nxt   = 8'(osw_pkg::LEAD_CYC - 1);
        end
      end
      osw_pkg::ST_LEAD: begin
        if (tmr_r == 8'h00) begin
          st_nxt   = osw_pkg::ST_HI;
          sclk_nxt = 1'b1;
          tmr_nxt  = 8'(HALF_CYC - 1);
        end else begin
          tmr_nxt = tmr_r - 8'h01;
        end
      end
      osw_pkg::ST_HI: begin
        if (tmr_r == 8'h00) begin
          // Status settled after rise; sample it before the fall
          st_nxt   = osw_pkg::ST_LO;
          sclk_nxt = 1'b0;
          rx_nxt   = {rx_r[6:0], sync2_r};  // see (R10)
          tmr_nxt  = 8'(HALF_CYC - 1);
        end else begin
          tmr_nxt = tmr_r - 8'h01;
        end
      end
      osw_pkg::ST_LO: begin
        if (tmr_r != 8'h00) begin
          tmr_nxt = tmr_r - 8'h01;
        end else if (bit_r == 3'(osw_pkg::WORD_BITS - 1)) begin  // see (R8)
          st_nxt  = osw_pkg::ST_LAG;
          tmr_nxt = 8'(osw_pkg::LAG_CYC - 1);
        end else begin
          // Data changes on the rise, far from the sampling fall
          st_nxt   = osw_pkg::ST_HI;
          sclk_nxt = 1'b1;
          tx_nxt   = {tx_r[6:0], 1'b0};
          mosi_nxt = tx_r[6];  // see (R9)
          bit_nxt  = bit_r + 3'h1;
          tmr_nxt  = 8'(HALF_CYC - 1);
        end
      end
      osw_pkg::ST_LAG: begin
        if (tmr_r == 8'h00) begin
          st_nxt        = osw_pkg::ST_IDLE;
          sel_n_nxt     = 1'b1;  // see (R4)
          mosi_nxt      = 1'b0;
          fault_nxt     = rx_r;  // see (R13)
          open_nxt      = rx_r & ~prev_r;  // see (R19)
          short_nxt     = rx_r & prev_r;  // see (R19)
          cls_valid_nxt = have_prev_r;
          prev_nxt      = sent_r;
          have_prev_nxt = 1'b1;
          gap_nxt       = 16'(GAP_CYC);  // see (R18)
        end else begin
          tmr_nxt = tmr_r - 8'h01;
        end
      end
      default: begin
        st_nxt = osw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r        <= osw_pkg::ST_IDLE;
      tmr_r       <= 8'h00;
      bit_r       <= 3'h0;
      tx_r        <= 8'h00;
      rx_r        <= 8'h00;
      sent_r      <= 8'h00;
      prev_r      <= 8'h00;
      have_prev_r <= 1'b0;
      cls_valid_r <= 1'b0;
      fault_r     <= 8'h00;
      open_r      <= 8'h00;
      short_r     <= 8'h00;
      gap_r       <= 16'h0000;
      sel_n_r     <= 1'b1;
      sclk_r      <= 1'b0;
      mosi_r      <= 1'b0;
      sync1_r     <= 1'b0;
      sync2_r     <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      tmr_r       <= tmr_nxt;
      bit_r       <= bit_nxt;
      tx_r        <= tx_nxt;
      rx_r        <= rx_nxt;
      sent_r      <= sent_nxt;
      prev_r      <= prev_nxt;
      have_prev_r <= have_prev_nxt;
      cls_valid_r <= cls_valid_nxt;
      fault_r     <= fault_nxt;
      open_r      <= open_nxt;
      short_r     <= short_nxt;
      gap_r       <= gap_nxt;
      sel_n_r     <= sel_n_nxt;
      sclk_r      <= sclk_nxt;
      mosi_r      <= mosi_nxt;
      sync1_r     <= switch_status_in;
      sync2_r     <= sync1_r;
    end
  end

  // ==========================================================
  // Direct-drive PWM channels
  for (genvar i = 0; i < 2; i++) begin : g_pwm
    osw_pwm #(
      .STEP_CYC (STEP_CYC)
    ) u_pwm (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .run     (ctrl_r[osw_pkg::CTRL_PWM5_BIT + i]),  // see (R16)
      .duty    (duty_r[8*i +: 8]),
      .pwm_out (pwm_out[i])
    );
  end

  assign rdata                  = rdata_r;
  assign pins.sel_n             = sel_n_r;
  assign pins.sclk              = sclk_r;
  assign pins.serial_cmd_in     = mosi_r;
  assign pins.direct_drive_five = pwm_out[0];  // see (R15)
  assign pins.direct_drive_six  = pwm_out[1];  // see (R15)
  assign pins.enable            = ctrl_r[osw_pkg::CTRL_EN_BIT];  // see (R14)

endmodule

// ==== tb/osw_dev_model.sv ====
// Behavioural model of the octal serial switch device
`timescale 1ns/10ps
module osw_dev_model (
  input  wire logic                  ref_clk,
  input  wire osw_pkg::osw_pins_type pins,
  input  wire logic [7:0]            fault_word,
  input  wire logic                  supply_low,
  output logic                       do_out,
  output logic [7:0]                 latch_q,
  output logic [7:0]                 drive_q
);
  logic [7:0] shreg;
  logic       do_r;
  logic       junk;
  initial begin
    shreg = 8'h00;
    latch_q = 8'h00;
    do_r = 1'b0;
    junk = 1'b0;
  end
  always @(posedge pins.sel_n) begin
    latch_q = supply_low ? 8'h00 : shreg;
  end
  always @(negedge pins.sel_n) begin
    shreg = (pins.enable && !supply_low) ? fault_word : 8'h00;
  end
  // Low logic supply drops every output at once
  always @(posedge supply_low) latch_q = 8'h00;
  always @(posedge pins.sclk) begin
    if (!pins.sel_n) do_r = shreg[7];
  end
  always @(negedge pins.sclk) begin
    if (!pins.sel_n) shreg = {shreg[6:0], pins.serial_cmd_in};
  end
  // Floating line: pattern that changes every cycle
  always @(posedge ref_clk) junk <= ~junk;
  assign do_out = pins.sel_n ? junk : do_r;
  assign drive_q = (pins.enable && !supply_low) ?
                   (latch_q | {2'b00, pins.direct_drive_six,
                   pins.direct_drive_five, 4'h0}) : 8'h00;
endmodule

// ==== tb/osw_asserts.sv ====
// Checker of the host serial pins and register port
`timescale 1ns/10ps
module osw_asserts #(
  parameter int GAP_CYC = osw_pkg::GAP_CYC
) (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire osw_pkg::osw_bus_type  bus,
  input wire logic [31:0]           rdata,
  input wire osw_pkg::osw_pins_type pins,
  input wire logic                  switch_status_in
);
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  logic [3:0]  rise_r;
  logic [3:0]  rise_nxt;
  logic        en_r;
  logic        en_nxt;
  logic        sel_d_r;
  logic        sck_d_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helper counters
  always_comb begin
    gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
    if (pins.sel_n && !sel_d_r) gap_nxt = 16'h1;
    rise_nxt = pins.sel_n ? 4'h0 : rise_r + 4'(pins.sclk && !sck_d_r);
    en_nxt = en_r;
    if (bus.wr && bus.addr == osw_pkg::OFS_CTRL) en_nxt = bus.wdata[0];
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gap_r <= 16'hffff;
      rise_r <= 4'h0;
      en_r <= 1'b0;
      sel_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      rise_r <= rise_nxt;
      en_r <= en_nxt;
      sel_d_r <= pins.sel_n;
      sck_d_r <= pins.sclk;
    end
  end
  // ==========================================================
  // Frame shape, frame spacing and enable pin
  sequence s_start;
    $fell(pins.sel_n) && !pins.sclk;
  endsequence
  sequence s_bit_one;
    !pins.sclk [*3] ##1 pins.sclk [*4] ##1 !pins.sclk;
  endsequence
  chk_lead_phase:
    assert property (s_start |-> s_bit_one) else $error("bad lead");
  chk_sel_sclk_low:
    assert property ($changed(pins.sel_n) |-> !pins.sclk && !$past(pins.sclk))
    else $error("sclk high at select edge");
  chk_idle_sclk_low:
    assert property (pins.sel_n |-> !pins.sclk) else $error("sclk idle high");
  chk_eight_clocks:
    assert property ($rose(pins.sel_n) |-> rise_r == 4'h8)
    else $error("clock count not eight");
  chk_frame_length:
    assert property ($fell(pins.sel_n) |-> ##68 !pins.sel_n ##1 pins.sel_n)
    else $error("frame length wrong");
  chk_gap_spacing:
    assert property ($fell(pins.sel_n) |-> gap_r >= GAP_CYC)
    else $error("frames too close");
  chk_data_setup:
    assert property ($fell(pins.sclk) |-> $stable(pins.serial_cmd_in))
    else $error("data moved at clock fall");
  chk_enable_follow:
    assert property (bus.wr && bus.addr == osw_pkg::OFS_CTRL |->
      ##[1:2] pins.enable == en_r) else $error("enable not following");
endmodule
bind osw_host osw_asserts #(.GAP_CYC(GAP_CYC)) u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .pins(pins),
  .switch_status_in(switch_status_in));

// ==== tb/osw_host_tb.sv ====
// Self-checking bench of the octal switch host
`timescale 1ns/10ps
module osw_host_tb;
  logic                  ref_clk;
  logic                  sys_rst;
  osw_pkg::osw_bus_type  bus;
  logic [31:0]           rdata;
  osw_pkg::osw_pins_type pins;
  logic                  do_line;
  logic [7:0]            fault_word;
  logic                  supply_low;
  logic [7:0]            latch_q;
  logic [7:0]            drive_q;
  logic [31:0]           d;
  logic [7:0]            cmd_t [3];
  logic [7:0]            flt_t [3];
  int                    err_count;
  int                    samples_checked;
  int                    cyc;
  int                    frames;
  int                    hi;
  osw_host #(.GAP_CYC(50), .STEP_CYC(2)) uut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus(bus),
    .rdata(rdata),
    .pins(pins),
    .switch_status_in(do_line)
  );
  osw_dev_model dev (
    .ref_clk(ref_clk),
    .pins(pins),
    .fault_word(fault_word),
    .supply_low(supply_low),
    .do_out(do_line),
    .latch_q(latch_q),
    .drive_q(drive_q)
  );
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge pins.sel_n) frames++;
  // ==========================================================
  // Tasks
  task end_of_test;
    $display("Counts: %0d compared, %0d mismatches", samples_checked,
             err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  // Waits for one whole frame, bounded
  task wait_xfer;
    int n;
    n = 0;
    while (pins.sel_n !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    while (pins.sel_n !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check(32'(n < 400), 32'h1);
    repeat (3) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      end_of_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    bus = '0;
    sys_rst = 1'b1;
    fault_word = 8'h00;
    supply_low = 1'b0;
    err_count = 0;
    samples_checked = 0;
    frames = 0;
    cyc = 0;
    cmd_t = '{8'ha5, 8'h5a, 8'h00};
    flt_t = '{8'h3c, 8'hc3, 8'hff};
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(osw_pkg::OFS_CTRL, 32'h0);
    rchk(osw_pkg::OFS_CMD, 32'h0);
    rchk(osw_pkg::OFS_FAULT, 32'h0);
    rchk(8'h20, 32'h0);
    check({31'h0, pins.sel_n}, 32'h1);
    $display("test reset: done");
    wr(osw_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(osw_pkg::OFS_CMD, {24'h0, cmd_t[i]});
      fault_word <= flt_t[i];
      wr(osw_pkg::OFS_GO, 32'h0);
      wait_xfer();
      check({24'h0, latch_q}, {24'h0, cmd_t[i]});
      check({24'h0, drive_q}, {24'h0, cmd_t[i]});
      rchk(osw_pkg::OFS_FAULT, {24'h0, flt_t[i]});
      rd(osw_pkg::OFS_STAT, d);
      check({31'h0, d[3]}, (i > 0) ? 32'h1 : 32'h0);
      if (i > 0) begin
        rchk(osw_pkg::OFS_OPEN, {24'h0, flt_t[i] & ~cmd_t[i-1]});
        rchk(osw_pkg::OFS_SHORT, {24'h0, flt_t[i] & cmd_t[i-1]});
      end
    end
    $display("test commands: done");
    wr(osw_pkg::OFS_CMD, 32'h81);
    wr(osw_pkg::OFS_GO, 32'h0);
    wr(osw_pkg::OFS_GO, 32'h0);
    rd(osw_pkg::OFS_STAT, d);
    check({31'h0, d[1]}, 32'h1);
    wait_xfer();
    repeat (150) @(posedge ref_clk);
    check({31'h0, pins.sel_n}, 32'h1);
    check(32'(frames), 32'h4);
    check({24'h0, latch_q}, 32'h81);
    $display("test pending go: done");
    wr(osw_pkg::OFS_DUTY, 32'h40);
    wr(osw_pkg::OFS_CTRL, 32'h3);
    wr(osw_pkg::OFS_CMD, 32'hff);
    wr(osw_pkg::OFS_GO, 32'h0);
    wait_xfer();
    check({24'h0, latch_q}, 32'hef);
    hi = 0;
    repeat (512) begin
      @(negedge ref_clk);
      if (pins.direct_drive_five === 1'b1) hi++;
    end
    check(32'(hi), 32'h80);
    check({31'h0, pins.direct_drive_six}, 32'h0);
    $display("test pwm: done");
    wr(osw_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1 check({31'h0, pins.enable}, 32'h0);
    check({24'h0, drive_q}, 32'h0);
    wr(osw_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 check({24'h0, drive_q}, 32'hef);
    $display("test enable: done");
    supply_low <= 1'b1;
    wr(osw_pkg::OFS_GO, 32'h0);
    wait_xfer();
    check({24'h0, latch_q}, 32'h0);
    check({24'h0, drive_q}, 32'h0);
    rchk(osw_pkg::OFS_FAULT, 32'h0);
    supply_low <= 1'b0;
    $display("test undervoltage: done");
    end_of_test();
  end
endmodule
